/* shared/ccr_pkg.sv */
// Constants, register map and bus carrier types for the clock and reset control block
package ccr_pkg;

  // Avalon-MM request bundle driven by the bus master
  typedef struct packed {
    logic        read;
    logic        write;
    logic [25:0] address;
    logic [3:0]  byteenable;
    logic [31:0] writedata;
  } ccr_avs_req_t;

  // Register indexes; byte address is four times the index
  localparam logic [23:0] CCR_IDX_CTRL       = 24'hff_fc40;
  localparam logic [23:0] CCR_IDX_FAST_PRESC = 24'hff_fc42;
  localparam logic [23:0] CCR_IDX_SLOW_PRESC = 24'hff_fc44;
  localparam logic [23:0] CCR_IDX_AUX_PRESC  = 24'hff_fc46;

  // Control register field positions
  localparam int unsigned CCR_BIT_SLOW_SEL = 0;
  localparam int unsigned CCR_BIT_FAST_SEL = 1;
  localparam int unsigned CCR_BIT_PLL_PWD  = 2;
  localparam int unsigned CCR_BIT_AUX1_EN  = 3;
  localparam int unsigned CCR_BIT_AUX2_EN  = 4;
  localparam int unsigned CCR_BIT_POR      = 5;

  // Prescaler field positions
  localparam int unsigned CCR_SYSDIV_LSB  = 0;
  localparam int unsigned CCR_SYSDIV_MSB  = 3;
  localparam int unsigned CCR_MODE_LSB    = 4;
  localparam int unsigned CCR_MODE_MSB    = 6;
  localparam int unsigned CCR_AUX1DIV_LSB = 0;
  localparam int unsigned CCR_AUX1DIV_MSB = 3;
  localparam int unsigned CCR_AUX2DIV_LSB = 4;
  localparam int unsigned CCR_AUX2DIV_MSB = 7;

  // Values after reset
  localparam logic       CCR_RST_SLOW_SEL   = 1'b0;
  localparam logic       CCR_RST_FAST_SEL   = 1'b1;
  localparam logic       CCR_RST_PLL_PWD    = 1'b1;
  localparam logic       CCR_RST_AUX_EN     = 1'b0;
  localparam logic       CCR_RST_POR        = 1'b1;
  localparam logic [7:0] CCR_RST_FAST_PRESC = 8'h4f;
  localparam logic [7:0] CCR_RST_SLOW_PRESC = 8'hb6;
  localparam logic [7:0] CCR_RST_AUX_PRESC  = 8'hff;
  localparam logic [13:0] CCR_POR_PRESET    = 14'h3fff;
  localparam logic [13:0] CCR_STABLE_PRESET = 14'h3fff;

  // PLL multiplication codes
  localparam logic [2:0] CCR_MODE_X3 = 3'b011;
  localparam logic [2:0] CCR_MODE_X4 = 3'b100;
  localparam logic [2:0] CCR_MODE_X5 = 3'b101;

  // Clock rates in MHz and PLL model accumulator wrap
  localparam int unsigned CCR_CLK_MHZ  = 250;
  localparam int unsigned CCR_MAIN_MHZ = 12;
  localparam logic [8:0]  CCR_ACC_WRAP = 9'h0fa;

  // PLL settling time, least time rounded up to cycles
  localparam int unsigned CCR_PLL_LOCK_NS  = 10000;
  localparam int unsigned CCR_PLL_LOCK_CYC = (CCR_PLL_LOCK_NS * CCR_CLK_MHZ + 999) / 1000;
  localparam logic [11:0] CCR_PLL_LOCK_MAX = 12'(CCR_PLL_LOCK_CYC - 1);

endpackage

/* hw/ccr_sync.sv */
// Two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
`default_nettype none
module ccr_sync #(
  parameter int unsigned W = 4
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  input  wire logic [W-1:0] i_d,
  output var  logic [W-1:0] o_q
);

  logic [W-1:0] meta_r;

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      meta_r <= '0;
      o_q    <= '0;
    end else begin
      meta_r <= i_d;
      o_q    <= meta_r;
    end
  end

endmodule
`default_nettype wire

/* hw/ccr_tick_div.sv */
// Programmable divider of a tick stream, emits one tick per (div + 1) source ticks
`timescale 1ns/1ps
`default_nettype none
module ccr_tick_div (
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_run,
  input  wire logic       i_src_tick,
  input  wire logic [8:0] i_div,
  output var  logic       o_tick
);

  logic [8:0] cnt_r;
  logic [8:0] cnt_nxt;
  wire        last = (cnt_r >= i_div);

  assign cnt_nxt = !i_run ? 9'h000 : !i_src_tick ? cnt_r : last ? 9'h000 : cnt_r + 9'h001;

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      cnt_r  <= 9'h000;
      o_tick <= 1'b0;
    end else begin
      cnt_r  <= cnt_nxt;
      o_tick <= i_run & i_src_tick & last;
    end
  end

endmodule
`default_nettype wire

/* hw/ccr_top.sv */
// Clock and reset control: PLL model, system, slow and auxiliary dividers, resets, registers
//
// Chosen here: register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
module ccr_top
  import ccr_pkg::*;
#(
  parameter logic [13:0] P_POR_PRESET    = CCR_POR_PRESET,
  parameter logic [13:0] P_STABLE_PRESET = CCR_STABLE_PRESET
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  input  wire ccr_avs_req_t i_avs_req,
  output var  logic         o_avs_waitrequest,
  output var  logic [31:0]  o_avs_readdata,
  input  wire logic         i_main_clk,
  input  wire logic         i_osc32k,
  input  wire logic         i_main_osc_stop,
  input  wire logic         i_ext_reset_n,
  output var  logic         o_sys_rst_n,
  output var  logic         o_main_stable,
  output var  logic         o_pll_locked,
  output var  logic         o_pll_tick,
  output var  logic         o_sys_tick,
  output var  logic         o_slow_tick,
  output var  logic         o_aux1_tick,
  output var  logic         o_aux2_tick,
  output var  logic         o_sys_on_pll
);

  // Index match on a word address
  function automatic logic ccr_hit(input logic [25:0] addr, input logic [23:0] idx);
    ccr_hit = (addr[25:2] == idx) && (addr[1:0] == 2'b00);
  endfunction

  // Pin synchronisers
  logic [3:0] pin_s;
  ccr_sync #(
    .W (4)
  ) u_sync (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_d     ({i_main_clk, i_osc32k, i_main_osc_stop, i_ext_reset_n}),
    .o_q     (pin_s)
  );

  wire main_s     = pin_s[3];
  wire osc32_s    = pin_s[2];
  wire osc_stop_s = pin_s[1];
  wire ext_rst_s  = pin_s[0];

  // Registers
  logic        main_d_r;
  logic        osc32_d_r;
  logic        wait_r;
  logic        slow_sel_r;
  logic        fast_sel_r;
  logic        pll_pwd_r;
  logic        aux1_en_r;
  logic        aux2_en_r;
  logic        por_flag_r;
  logic [7:0]  fast_presc_r;
  logic [7:0]  slow_presc_r;
  logic [7:0]  aux_presc_r;
  logic [13:0] por_cnt_r;
  logic [13:0] stable_cnt_r;
  logic [8:0]  pll_acc_r;
  logic [11:0] lock_cnt_r;
  logic [2:0]  mode_seen_r;
  logic        sel_pll_r;

  // Edge detection on synchronised clock pins
  wire main_tick  = main_s & ~main_d_r;
  wire osc32_tick = osc32_s & ~osc32_d_r;

  // Bus decode
  wire        req_any  = i_avs_req.read | i_avs_req.write;
  wire        wr_acc   = i_avs_req.write & ~wait_r & i_avs_req.byteenable[0];
  wire [7:0]  wd       = i_avs_req.writedata[7:0];
  wire        hit_ctrl = ccr_hit(i_avs_req.address, CCR_IDX_CTRL);
  wire        hit_fast = ccr_hit(i_avs_req.address, CCR_IDX_FAST_PRESC);
  wire        hit_slow = ccr_hit(i_avs_req.address, CCR_IDX_SLOW_PRESC);
  wire        hit_aux  = ccr_hit(i_avs_req.address, CCR_IDX_AUX_PRESC);
  wire        wr_ctrl  = wr_acc & hit_ctrl;
  wire        wr_fast  = wr_acc & hit_fast;
  wire        wr_slow  = wr_acc & hit_slow;
  wire        wr_aux   = wr_acc & hit_aux;

  // PLL model
  wire [2:0] pll_mode   = fast_presc_r[CCR_MODE_MSB:CCR_MODE_LSB];
  wire       mode_ok    = (pll_mode == CCR_MODE_X3) || (pll_mode == CCR_MODE_X4) ||
                          (pll_mode == CCR_MODE_X5);
  wire       pll_run    = ~pll_pwd_r & o_main_stable & mode_ok;
  wire [8:0] pll_step   = 9'(pll_mode * CCR_MAIN_MHZ);
  wire [8:0] pll_sum    = pll_acc_r + pll_step;
  wire       pll_wrap   = (pll_sum >= CCR_ACC_WRAP);
  wire [8:0] pll_acc_nxt = !pll_run ? 9'h000 : pll_wrap ? pll_sum - CCR_ACC_WRAP : pll_sum;
  wire       lock_done  = (lock_cnt_r == CCR_PLL_LOCK_MAX);
  wire       lock_clr   = !pll_run || (pll_mode != mode_seen_r);
  wire [11:0] lock_nxt  = lock_clr ? 12'h000 : lock_done ? lock_cnt_r : lock_cnt_r + 12'h001;

  // Control field next values
  wire fast_clr_ok  = ~pll_pwd_r & o_pll_locked;
  wire fast_sel_nxt = !wr_ctrl ? fast_sel_r :
                      wd[CCR_BIT_FAST_SEL] ? 1'b1 :
                      fast_clr_ok ? 1'b0 : fast_sel_r;
  wire pll_pwd_nxt  = !wr_ctrl ? pll_pwd_r :
                      !wd[CCR_BIT_PLL_PWD] ? 1'b0 :
                      fast_sel_r ? 1'b1 : pll_pwd_r;
  wire por_flag_nxt = (wr_ctrl && !wd[CCR_BIT_POR]) ? 1'b0 : por_flag_r;

  // Counters
  wire [13:0] por_cnt_nxt    = (main_tick && por_cnt_r != 14'h0000) ?
                               por_cnt_r - 14'h0001 : por_cnt_r;
  wire [13:0] stable_cnt_nxt = osc_stop_s ? P_STABLE_PRESET :
                               (main_tick && stable_cnt_r != 14'h0000) ?
                               stable_cnt_r - 14'h0001 : stable_cnt_r;

  // Clock source selection
  wire       sys_src      = sel_pll_r ? o_pll_tick : main_tick;
  wire [8:0] sys_div      = {5'h00, fast_presc_r[CCR_SYSDIV_MSB:CCR_SYSDIV_LSB]};
  wire       sel_pll_nxt  = (o_sys_tick || !o_main_stable) ? ~fast_sel_r : sel_pll_r;
  wire       slow_src     = slow_sel_r ? osc32_tick : main_tick;
  wire [8:0] slow_div     = slow_sel_r ? 9'h000 : {slow_presc_r, 1'b1};
  wire [8:0] aux1_div     = {5'h00, aux_presc_r[CCR_AUX1DIV_MSB:CCR_AUX1DIV_LSB]};
  wire [8:0] aux2_div     = {5'h00, aux_presc_r[CCR_AUX2DIV_MSB:CCR_AUX2DIV_LSB]};
  wire       aux1_run     = aux1_en_r & o_main_stable;
  wire       aux2_run     = aux2_en_r & o_main_stable;

  // Read data
  wire [7:0] ctrl_rd = {2'b00, por_flag_r, aux2_en_r, aux1_en_r, pll_pwd_r, fast_sel_r,
                        slow_sel_r};
  wire [7:0] rd_byte = hit_ctrl ? ctrl_rd :
                       hit_fast ? fast_presc_r :
                       hit_slow ? slow_presc_r :
                       hit_aux  ? aux_presc_r : 8'h00;

  // Bus handshake: one wait cycle per request
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      wait_r            <= 1'b1;
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata    <= 32'h0000_0000;
    end else begin
      wait_r            <= ~(req_any & wait_r);
      o_avs_waitrequest <= ~(req_any & wait_r);
      if (i_avs_req.read && wait_r) begin
        o_avs_readdata <= {24'h00_0000, rd_byte};
      end
    end
  end

  // Control register
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      slow_sel_r <= CCR_RST_SLOW_SEL;
      fast_sel_r <= CCR_RST_FAST_SEL;
      pll_pwd_r  <= CCR_RST_PLL_PWD;
      aux1_en_r  <= CCR_RST_AUX_EN;
      aux2_en_r  <= CCR_RST_AUX_EN;
      por_flag_r <= CCR_RST_POR;
    end else begin
      fast_sel_r <= fast_sel_nxt;
      pll_pwd_r  <= pll_pwd_nxt;
      por_flag_r <= por_flag_nxt;
      if (wr_ctrl) begin
        slow_sel_r <= wd[CCR_BIT_SLOW_SEL];
        aux1_en_r  <= wd[CCR_BIT_AUX1_EN];
        aux2_en_r  <= wd[CCR_BIT_AUX2_EN];
      end
    end
  end

  // Prescaler registers
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      fast_presc_r <= CCR_RST_FAST_PRESC;
      slow_presc_r <= CCR_RST_SLOW_PRESC;
      aux_presc_r  <= CCR_RST_AUX_PRESC;
    end else begin
      if (wr_fast) begin
        fast_presc_r <= {1'b0, wd[6:0]};
      end
      if (wr_slow) begin
        slow_presc_r <= wd;
      end
      if (wr_aux) begin
        aux_presc_r <= wd;
      end
    end
  end

  // Edge detectors and counters
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      main_d_r     <= 1'b0;
      osc32_d_r    <= 1'b0;
      por_cnt_r    <= P_POR_PRESET;
      stable_cnt_r <= P_STABLE_PRESET;
    end else begin
      main_d_r     <= main_s;
      osc32_d_r    <= osc32_s;
      por_cnt_r    <= por_cnt_nxt;
      stable_cnt_r <= stable_cnt_nxt;
    end
  end

  // PLL tick generator and settling counter
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      pll_acc_r    <= 9'h000;
      lock_cnt_r   <= 12'h000;
      mode_seen_r  <= CCR_MODE_X4;
      o_pll_tick   <= 1'b0;
      o_pll_locked <= 1'b0;
    end else begin
      pll_acc_r    <= pll_acc_nxt;
      lock_cnt_r   <= lock_nxt;
      mode_seen_r  <= pll_mode;
      o_pll_tick   <= pll_run & pll_wrap;
      o_pll_locked <= ~lock_clr & lock_done;
    end
  end

  // Reset and status outputs
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_sys_rst_n   <= 1'b0;
      o_main_stable <= 1'b0;
      sel_pll_r     <= 1'b0;
      o_sys_on_pll  <= 1'b0;
    end else begin
      o_sys_rst_n   <= (por_cnt_r == 14'h0000) & ext_rst_s;
      o_main_stable <= (stable_cnt_r == 14'h0000) & ~osc_stop_s;
      sel_pll_r     <= sel_pll_nxt;
      o_sys_on_pll  <= sel_pll_nxt;
    end
  end

  // System clock divider
  ccr_tick_div u_sys_div (
    .i_clk      (i_clk),
    .i_rst_n    (i_rst_n),
    .i_run      (1'b1),
    .i_src_tick (sys_src),
    .i_div      (sys_div),
    .o_tick     (o_sys_tick)
  );

  // Slow clock divider
  ccr_tick_div u_slow_div (
    .i_clk      (i_clk),
    .i_rst_n    (i_rst_n),
    .i_run      (1'b1),
    .i_src_tick (slow_src),
    .i_div      (slow_div),
    .o_tick     (o_slow_tick)
  );

  // Auxiliary clock dividers
  ccr_tick_div u_aux1_div (
    .i_clk      (i_clk),
    .i_rst_n    (i_rst_n),
    .i_run      (aux1_run),
    .i_src_tick (main_tick),
    .i_div      (aux1_div),
    .o_tick     (o_aux1_tick)
  );

  ccr_tick_div u_aux2_div (
    .i_clk      (i_clk),
    .i_rst_n    (i_rst_n),
    .i_run      (aux2_run),
    .i_src_tick (main_tick),
    .i_div      (aux2_div),
    .o_tick     (o_aux2_tick)
  );

endmodule
`default_nettype wire

/* verif/ccr_chk.sv */
// Bus, reset and clock-gating checks for the clock and reset control block
`timescale 1ns/1ps
`default_nettype none
module ccr_chk
  import ccr_pkg::*;
(
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  input  wire ccr_avs_req_t i_avs_req,
  input  wire logic         o_avs_waitrequest,
  input  wire logic [31:0]  o_avs_readdata,
  input  wire logic         i_ext_reset_n,
  input  wire logic         o_sys_rst_n,
  input  wire logic         o_main_stable,
  input  wire logic         o_pll_locked,
  input  wire logic         o_pll_tick,
  input  wire logic         o_sys_tick,
  input  wire logic         o_aux1_tick,
  input  wire logic         o_aux2_tick,
  input  wire logic         o_sys_on_pll
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  wire logic req_on;
  wire logic mapped;
  assign req_on = i_avs_req.read || i_avs_req.write;
  assign mapped = i_avs_req.address inside {26'h3ff_f100, 26'h3ff_f108,
                                            26'h3ff_f110, 26'h3ff_f118};
  chk_one_wait: assert property (req_on && o_avs_waitrequest |=> !o_avs_waitrequest)
    else $error("waitrequest not released after one wait state");
  chk_wait_pulse: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  chk_no_spurious: assert property (!req_on && o_avs_waitrequest |=> o_avs_waitrequest)
    else $error("waitrequest dropped without a request");
  chk_unmapped_zero: assert property (i_avs_req.read && !mapped && !o_avs_waitrequest
    |-> o_avs_readdata == 32'h0000_0000) else $error("unmapped read not zero");
  chk_pin_reset: assert property (!i_ext_reset_n [*4] |-> !o_sys_rst_n)
    else $error("system reset not held by reset pin");
  chk_release_pin: assert property ($rose(o_sys_rst_n)
    |-> i_ext_reset_n && $past(i_ext_reset_n, 2))
    else $error("system reset released while pin low");
  chk_aux1_gate: assert property (!o_main_stable [*3] |-> !o_aux1_tick)
    else $error("aux clock 1 runs without stable main clock");
  chk_aux2_gate: assert property (!o_main_stable [*3] |-> !o_aux2_tick)
    else $error("aux clock 2 runs without stable main clock");
  chk_pll_switch: assert property ($rose(o_sys_on_pll) |-> o_pll_locked && o_main_stable)
    else $error("system moved to unsettled PLL");
  chk_pll_rate: assert property (o_pll_tick |=> !o_pll_tick)
    else $error("PLL ticks too fast");
  chk_switch_edge: assert property ($changed(o_sys_on_pll)
    |-> $past(o_sys_tick) || !$past(o_main_stable))
    else $error("system clock source switched inside a divider period");
  cover property ($rose(o_sys_on_pll));
  cover property ($fell(o_sys_rst_n) && o_main_stable);
  cover property (o_aux2_tick);
endmodule
bind ccr_top ccr_chk ccr_chk_inst (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .i_avs_req(i_avs_req),
  .o_avs_waitrequest(o_avs_waitrequest), .o_avs_readdata(o_avs_readdata),
  .i_ext_reset_n(i_ext_reset_n), .o_sys_rst_n(o_sys_rst_n), .o_main_stable(o_main_stable),
  .o_pll_locked(o_pll_locked), .o_pll_tick(o_pll_tick), .o_aux1_tick(o_aux1_tick),
  .o_aux2_tick(o_aux2_tick), .o_sys_on_pll(o_sys_on_pll), .o_sys_tick(o_sys_tick)
);
`default_nettype wire

/* verif/tb.sv */
// Self-checking bench for the clock and reset control block
`timescale 1ns/1ps
`default_nettype none
module tb
  import ccr_pkg::*;
;
  localparam logic [25:0] A_CTRL = 26'h3ff_f100;
  localparam logic [25:0] A_FAST = 26'h3ff_f108;
  localparam logic [25:0] A_SLOW = 26'h3ff_f110;
  localparam logic [25:0] A_AUX  = 26'h3ff_f118;
  localparam logic [25:0] A_NONE = 26'h3ff_f120;
  logic         i_clk, i_rst_n, i_main_clk, i_osc32k, i_main_osc_stop, i_ext_reset_n;
  logic         o_avs_waitrequest, o_sys_rst_n, o_main_stable, o_pll_locked, o_sys_on_pll;
  logic         o_pll_tick, o_sys_tick, o_slow_tick, o_aux1_tick, o_aux2_tick;
  logic [31:0]  o_avs_readdata;
  ccr_avs_req_t i_avs_req;
  logic [7:0]   q;
  int           err_count, num_checks, mdiv;
  logic [31:0]  cnt[5];
  logic [2:0]   modes[4] = '{3'h3, 3'h4, 3'h5, 3'h0};
  int           rates[4] = '{144, 192, 240, 0};

  ccr_top #(.P_POR_PRESET(14'h0010), .P_STABLE_PRESET(14'h0010)) ccr_top_inst (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_avs_req(i_avs_req),
    .o_avs_waitrequest(o_avs_waitrequest), .o_avs_readdata(o_avs_readdata),
    .i_main_clk(i_main_clk), .i_osc32k(i_osc32k), .i_main_osc_stop(i_main_osc_stop),
    .i_ext_reset_n(i_ext_reset_n), .o_sys_rst_n(o_sys_rst_n), .o_main_stable(o_main_stable),
    .o_pll_locked(o_pll_locked), .o_pll_tick(o_pll_tick), .o_sys_tick(o_sys_tick),
    .o_slow_tick(o_slow_tick), .o_aux1_tick(o_aux1_tick), .o_aux2_tick(o_aux2_tick),
    .o_sys_on_pll(o_sys_on_pll)
  );

  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end

  // Main clock of 20 cycles, slow oscillator of 100 cycles
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      mdiv       <= 0;
      i_main_clk <= 1'b0;
      i_osc32k   <= 1'b0;
    end else begin
      mdiv <= (mdiv + 1) % 100;
      if (mdiv % 10 == 9) i_main_clk <= ~i_main_clk;
      if (mdiv % 50 == 49) i_osc32k <= ~i_osc32k;
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic check1(input logic s, input logic e);
    check(32'(s), 32'(e));
  endtask
  task automatic near(input logic [31:0] c, input int e, input int tol);
    check((c >= e - tol && c <= e + tol) ? e : c, e);
  endtask
  task automatic bus(input logic wr, input logic [25:0] a, input logic [7:0] d);
    i_avs_req <= '{read: !wr, write: wr, address: a, byteenable: 4'hf,
                   writedata: {24'h00_0000, d}};
    do begin
      @(posedge i_clk);
    end while (o_avs_waitrequest !== 1'b0);
    q = o_avs_readdata[7:0];
    i_avs_req <= '0;
    @(posedge i_clk);
  endtask
  task automatic rd_chk(input logic [25:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    check(32'(q), 32'(e));
  endtask
  task automatic measure(input int n);
    cnt = '{default: 0};
    repeat (n) begin
      @(posedge i_clk);
      cnt[0] += o_pll_tick;
      cnt[1] += o_sys_tick;
      cnt[2] += o_slow_tick;
      cnt[3] += o_aux1_tick;
      cnt[4] += o_aux2_tick;
    end
  endtask
  task automatic close_out();
    if (err_count == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge i_clk);
    err_count++;
    close_out();
  end

  initial begin
    err_count = 0;
    num_checks = 0;
    i_rst_n = 1'b0;
    i_main_osc_stop = 1'b0;
    i_ext_reset_n = 1'b1;
    i_avs_req = '0;
    repeat (20) @(posedge i_clk);
    i_rst_n <= 1'b1;
    repeat (100) @(posedge i_clk);
    check1(o_sys_rst_n, 1'b0);
    for (int i = 0; i < 2000 && !(o_sys_rst_n === 1'b1 && o_main_stable === 1'b1); i++)
      @(posedge i_clk);
    check1(o_sys_rst_n, 1'b1);
    check1(o_main_stable, 1'b1);
    rd_chk(A_CTRL, 8'h26);
    rd_chk(A_FAST, 8'h4f);
    rd_chk(A_SLOW, 8'hb6);
    rd_chk(A_AUX, 8'hff);
    bus(1'b1, A_NONE, 8'h5a);
    rd_chk(A_NONE, 8'h00);
    bus(1'b1, A_CTRL, 8'h04);
    rd_chk(A_CTRL, 8'h06);
    bus(1'b1, A_CTRL, 8'h26);
    rd_chk(A_CTRL, 8'h06);
    measure(300);
    check(cnt[0], 0);
    // PLL start with the settle handshake
    bus(1'b1, A_FAST, 8'h41);
    bus(1'b1, A_CTRL, 8'h02);
    bus(1'b1, A_CTRL, 8'h00);
    rd_chk(A_CTRL, 8'h02);
    for (int i = 0; i < 1000 && q[1] !== 1'b0; i++) begin
      bus(1'b1, A_CTRL, 8'h00);
      bus(1'b0, A_CTRL, 8'h00);
    end
    check1(o_pll_locked, 1'b1);
    check1(q[1], 1'b0);
    bus(1'b1, A_CTRL, 8'h04);
    rd_chk(A_CTRL, 8'h00);
    for (int i = 0; i < 100 && o_sys_on_pll !== 1'b1; i++) @(posedge i_clk);
    check1(o_sys_on_pll, 1'b1);
    measure(1000);
    check(cnt[0], 192);
    near(cnt[1], 96, 1);
    bus(1'b1, A_CTRL, 8'h02);
    for (int i = 0; i < 100 && o_sys_on_pll !== 1'b0; i++) @(posedge i_clk);
    check1(o_sys_on_pll, 1'b0);
    measure(1000);
    near(cnt[1], 25, 1);
    foreach (modes[m]) begin
      bus(1'b1, A_FAST, {1'b0, modes[m], 4'h1});
      measure(2600);
      measure(1000);
      check(cnt[0], rates[m]);
      check1(o_pll_locked, m < 3);
    end
    bus(1'b1, A_FAST, 8'h4f);
    measure(2000);
    near(cnt[1], 6, 1);
    // Slow and auxiliary dividers, gated and running
    bus(1'b1, A_SLOW, 8'h04);
    bus(1'b1, A_AUX, 8'h31);
    measure(1000);
    near(cnt[2], 5, 1);
    check(cnt[3] + cnt[4], 0);
    bus(1'b1, A_CTRL, 8'h1b);
    measure(1000);
    near(cnt[2], 10, 1);
    near(cnt[3], 25, 1);
    near(cnt[4], 12, 1);
    i_main_osc_stop <= 1'b1;
    repeat (10) @(posedge i_clk);
    check1(o_main_stable, 1'b0);
    measure(500);
    check(cnt[3] + cnt[4], 0);
    i_main_osc_stop <= 1'b0;
    // Reset pin pulse
    i_ext_reset_n <= 1'b0;
    repeat (8) @(posedge i_clk);
    check1(o_sys_rst_n, 1'b0);
    i_ext_reset_n <= 1'b1;
    for (int i = 0; i < 100 && o_sys_rst_n !== 1'b1; i++) @(posedge i_clk);
    check1(o_sys_rst_n, 1'b1);
    close_out();
  end
endmodule
`default_nettype wire
